// ---- hdl/rsc_defines.svh ----
// constants of the redundancy switchover control block
// Operation
// [R1] master picks secondary only if primary open, secondary closed
// [R2] active contacts follow the selected processor
// [R3] master decides from both watch inputs, forwards on chain
// [R4] slave ignores primary watch, follows secondary watch
// [R5] fault contact opens only in slave with line fault
// [R6] fault indicator lights on the same condition
// [R7] secondary-labelled indicator lights while primary active
// [R8] primary-labelled indicator lights while secondary active
// [R9] chain output level tells which processor is active
// [R10] primary active routes every channel to primary
// [R11] primary failure switches all channels to secondary automatically
// [R12] eight output contacts follow the active processor
// [R13] nine evacuation inputs routed to active processor
// [R14] two peripheral controller port sets follow active side
// [R15] telephone lines and record follow active processor
// [R16] each processor drives its watch input from bypass
// [R17] static role switch selects master or slave
// [R18] contact inputs synchronised and debounced before use
`ifndef RSC_DEFINES_SVH
`define RSC_DEFINES_SVH
`define RSC_CLK_MHZ 125
`define RSC_DEBOUNCE_US 5000
`define RSC_AW 4
`define RSC_DW 8
`define RSC_REG_STATE 4'h0
`define RSC_REG_STATUS 4'h4
`define RSC_REG_CLEAR 4'h8
`define RSC_REG_ENABLE 4'hc
`define RSC_ST_TO_SEC 0
`define RSC_ST_TO_PRI 1
`define RSC_ST_FAULT 2
`define RSC_EV_W 3
`define RSC_EV_RST 3'h0
`define RSC_EN_RST 3'h0
`define RSC_RD_ZERO 8'h00
`endif

// ---- hdl/rsc_pkg.sv ----
// types shared by the redundancy switchover control block
package rsc_pkg;
   typedef enum logic {
      RSC_SEL_PRIMARY,
      RSC_SEL_SECONDARY
   } rsc_sel_e;

   // debounced contact levels, 1 = contact closed
   typedef struct packed {
      logic primary_watch;
      logic secondary_watch;
      logic role_slave;
      logic line_short;
      logic line_open;
   } rsc_watch_s;

   typedef struct packed {
      logic fault;
      logic to_primary;
      logic to_secondary;
   } rsc_event_s;
endpackage : rsc_pkg

// ---- hdl/rsc_switchover.sv ----
// redundancy switchover control: decision, channel steering, registers
`timescale 1ns/1ps
`include "rsc_defines.svh"

module rsc_debounce #(
   parameter int STABLE_CYC = 16
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic raw_i,
   output logic level_o
);
   localparam int CW = $clog2(STABLE_CYC + 1);
   logic sync_a;
   logic sync_b;
   logic [CW-1:0] cnt;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         sync_a <= 1'b0;
         sync_b <= 1'b0;
      end else begin
         sync_a <= raw_i;
         sync_b <= sync_a;
      end
   end

   // level changes only after it has stood still long enough
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         cnt <= '0;
         level_o <= 1'b0;
      end else if (sync_b == level_o) begin
         cnt <= '0;
      end else if (cnt == CW'(STABLE_CYC - 1)) begin
         cnt <= '0;
         level_o <= sync_b;
      end else begin
         cnt <= cnt + CW'(1);
      end
   end

   a_db_hold_time: assert property ( // [R18]
      @(posedge clk_i) disable iff (rst_i)
      $changed(level_o) |-> $past(cnt) == CW'(STABLE_CYC - 1))
      else $error("debounced level moved before hold time");
   a_db_restart: assert property ( // [R18]
      @(posedge clk_i) disable iff (rst_i)
      (sync_b == level_o) |=> cnt == '0)
      else $error("debounce count not restarted");
   a_db_count_max: assert property ( // [R18]
      @(posedge clk_i) disable iff (rst_i)
      cnt <= CW'(STABLE_CYC - 1))
      else $error("debounce count beyond hold time");
endmodule : rsc_debounce

module rsc_switchover import rsc_pkg::*; #(
   parameter int STABLE_CYC = `RSC_DEBOUNCE_US * `RSC_CLK_MHZ,
   parameter int N_OUT = 8,
   parameter int N_EVAC = 9,
   parameter int N_PERIPH = 2
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic primary_watch_input_i,
   input wire logic secondary_watch_input_i,
   input wire logic role_slave_i,
   input wire logic secondary_line_short_i,
   input wire logic secondary_line_open_i,
   input wire logic [N_OUT-1:0] out_contact_pri_i,
   input wire logic [N_OUT-1:0] out_contact_sec_i,
   input wire logic [N_EVAC-1:0] evac_common_i,
   input wire logic [N_PERIPH-1:0] periph_port_rx_i,
   input wire logic [N_PERIPH-1:0] periph_port_pri_rx_i,
   input wire logic [N_PERIPH-1:0] periph_port_sec_rx_i,
   input wire logic [`RSC_AW-1:0] reg_addr_i,
   input wire logic [`RSC_DW-1:0] reg_wdata_i,
   input wire logic reg_wr_i,
   input wire logic reg_rd_i,
   output logic [`RSC_DW-1:0] reg_rdata_o,
   output logic irq_o,
   output logic primary_active_contact_o,
   output logic secondary_active_contact_o,
   output logic active_state_chain_out_o,
   output logic fault_contact_closed_o,
   output logic fault_led_o,
   output logic led_secondary_label_o,
   output logic led_primary_label_o,
   output logic [N_OUT-1:0] out_contact_o,
   output logic [N_EVAC-1:0] evac_to_pri_o,
   output logic [N_EVAC-1:0] evac_to_sec_o,
   output logic [N_PERIPH-1:0] periph_port_tx_o,
   output logic [N_PERIPH-1:0] periph_port_pri_tx_o,
   output logic [N_PERIPH-1:0] periph_port_sec_tx_o,
   output logic tel_route_secondary_o
);
   rsc_watch_s db;
   rsc_sel_e sel;
   rsc_sel_e next_sel;
   rsc_event_s ev;
   logic fault;
   logic next_fault;
   logic [`RSC_EV_W-1:0] status;
   logic [`RSC_EV_W-1:0] enable;
   logic [`RSC_EV_W-1:0] clr;

   // [R18] debounce the watch, role and line contacts
   rsc_debounce #(.STABLE_CYC(STABLE_CYC)) u_db_pri (
      .clk_i(clk_i), .rst_i(rst_i),
      .raw_i(primary_watch_input_i), .level_o(db.primary_watch));
   rsc_debounce #(.STABLE_CYC(STABLE_CYC)) u_db_sec (
      .clk_i(clk_i), .rst_i(rst_i),
      .raw_i(secondary_watch_input_i), .level_o(db.secondary_watch));
   rsc_debounce #(.STABLE_CYC(STABLE_CYC)) u_db_role (
      .clk_i(clk_i), .rst_i(rst_i),
      .raw_i(role_slave_i), .level_o(db.role_slave));
   rsc_debounce #(.STABLE_CYC(STABLE_CYC)) u_db_short (
      .clk_i(clk_i), .rst_i(rst_i),
      .raw_i(secondary_line_short_i), .level_o(db.line_short));
   rsc_debounce #(.STABLE_CYC(STABLE_CYC)) u_db_open (
      .clk_i(clk_i), .rst_i(rst_i),
      .raw_i(secondary_line_open_i), .level_o(db.line_open));

   always_comb begin
      // [R17] role switch picks decision source
      if (db.role_slave) begin
         // [R4] slave follows chained secondary watch
         next_sel = db.secondary_watch ? RSC_SEL_SECONDARY : RSC_SEL_PRIMARY;
      end else begin
         // [R1] [R3] [R11] master truth table
         next_sel = (!db.primary_watch && db.secondary_watch) ?
                    RSC_SEL_SECONDARY : RSC_SEL_PRIMARY;
      end
      // [R5] line fault counts only in slave role
      next_fault = db.role_slave && (db.line_short || db.line_open);
   end

   // primary after reset: it holds priority when nothing is known
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         sel <= RSC_SEL_PRIMARY;
         fault <= 1'b0;
      end else begin
         sel <= next_sel;
         fault <= next_fault;
      end
   end

   // [R2] [R9] status contacts and chain level
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         primary_active_contact_o <= 1'b1;
         secondary_active_contact_o <= 1'b0;
         active_state_chain_out_o <= 1'b0;
         led_secondary_label_o <= 1'b1;
         led_primary_label_o <= 1'b0;
      end else begin
         primary_active_contact_o <= (sel == RSC_SEL_PRIMARY);
         secondary_active_contact_o <= (sel == RSC_SEL_SECONDARY);
         active_state_chain_out_o <= (sel == RSC_SEL_SECONDARY);
         // [R7] [R8] indicator labels are swapped on purpose
         led_secondary_label_o <= (sel == RSC_SEL_PRIMARY);
         led_primary_label_o <= (sel == RSC_SEL_SECONDARY);
      end
   end

   // [R5] [R6] fault contact and indicator
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         fault_contact_closed_o <= 1'b1;
         fault_led_o <= 1'b0;
      end else begin
         fault_contact_closed_o <= !fault;
         fault_led_o <= fault;
      end
   end

   // [R10] [R12] [R13] [R14] [R15] channel steering
   // inactive side sees an open contact, never a stale copy
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         out_contact_o <= '0;
         evac_to_pri_o <= '0;
         evac_to_sec_o <= '0;
         periph_port_tx_o <= '0;
         periph_port_pri_tx_o <= '0;
         periph_port_sec_tx_o <= '0;
         tel_route_secondary_o <= 1'b0;
      end else if (sel == RSC_SEL_SECONDARY) begin
         out_contact_o <= out_contact_sec_i;
         evac_to_pri_o <= '0;
         evac_to_sec_o <= evac_common_i;
         periph_port_tx_o <= periph_port_sec_rx_i;
         periph_port_pri_tx_o <= '0;
         periph_port_sec_tx_o <= periph_port_rx_i;
         tel_route_secondary_o <= 1'b1;
      end else begin
         out_contact_o <= out_contact_pri_i;
         evac_to_pri_o <= evac_common_i;
         evac_to_sec_o <= '0;
         periph_port_tx_o <= periph_port_pri_rx_i;
         periph_port_pri_tx_o <= periph_port_rx_i;
         periph_port_sec_tx_o <= '0;
         tel_route_secondary_o <= 1'b0;
      end
   end

   assign ev.to_secondary = (sel == RSC_SEL_PRIMARY) && (next_sel == RSC_SEL_SECONDARY);
   assign ev.to_primary = (sel == RSC_SEL_SECONDARY) && (next_sel == RSC_SEL_PRIMARY);
   assign ev.fault = !fault && next_fault;
   assign clr = (reg_wr_i && reg_addr_i == `RSC_REG_CLEAR) ?
                reg_wdata_i[`RSC_EV_W-1:0] : `RSC_EV_RST;

   // sticky events; a set in the clearing cycle survives
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         status <= `RSC_EV_RST;
      end else begin
         status <= (status & ~clr) | ev;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         enable <= `RSC_EN_RST;
      end else if (reg_wr_i && reg_addr_i == `RSC_REG_ENABLE) begin
         enable <= reg_wdata_i[`RSC_EV_W-1:0];
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         irq_o <= 1'b0;
      end else begin
         irq_o <= |(((status & ~clr) | ev) & enable);
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i || !reg_rd_i) begin
         reg_rdata_o <= `RSC_RD_ZERO;
      end else begin
         case (reg_addr_i)
            `RSC_REG_STATE: reg_rdata_o <= {1'b0, db, fault, sel};
            `RSC_REG_STATUS: reg_rdata_o <= {{(`RSC_DW-`RSC_EV_W){1'b0}}, status};
            `RSC_REG_ENABLE: reg_rdata_o <= {{(`RSC_DW-`RSC_EV_W){1'b0}}, enable};
            default: reg_rdata_o <= `RSC_RD_ZERO;
         endcase
      end
   end

   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);

   a_master_sec_pick: assert property ( // [R1]
      (!db.role_slave && !db.primary_watch && db.secondary_watch)
      |=> ##1 secondary_active_contact_o)
      else $error("master did not pick secondary");
   a_master_pri_pick: assert property ( // [R1]
      (!db.role_slave && (db.primary_watch || !db.secondary_watch))
      |=> ##1 primary_active_contact_o)
      else $error("master did not pick primary");
   a_contacts_exclusive: assert property ( // [R2]
      primary_active_contact_o != secondary_active_contact_o)
      else $error("active contacts not complementary");
   a_chain_level: assert property ( // [R9]
      active_state_chain_out_o == secondary_active_contact_o)
      else $error("chain level disagrees with active side");
   a_slave_follow: assert property ( // [R4]
      db.role_slave |=> ##1 (secondary_active_contact_o == $past(db.secondary_watch, 2)))
      else $error("slave did not follow secondary watch");
   a_fault_open: assert property ( // [R5]
      next_fault |=> ##1 !fault_contact_closed_o)
      else $error("fault contact not opened");
   a_fault_master: assert property ( // [R5]
      !db.role_slave |=> ##1 fault_contact_closed_o)
      else $error("fault contact opened in master role");
   a_fault_led: assert property ( // [R6]
      fault_led_o == !fault_contact_closed_o)
      else $error("fault indicator disagrees with contact");
   a_led_swap: assert property ( // [R7]
      led_secondary_label_o == primary_active_contact_o
      && led_primary_label_o == secondary_active_contact_o)
      else $error("indicator labels not swapped");
   a_out_route: assert property ( // [R12]
      !$past(rst_i) |-> out_contact_o == (secondary_active_contact_o ?
      $past(out_contact_sec_i) : $past(out_contact_pri_i)))
      else $error("output contacts from wrong side");
   a_evac_route: assert property ( // [R13]
      primary_active_contact_o |-> evac_to_sec_o == '0)
      else $error("evacuation input sent to inactive side");
   a_tel_route: assert property ( // [R15]
      tel_route_secondary_o == secondary_active_contact_o)
      else $error("telephone route disagrees with active side");
   a_fail_over: assert property ( // [R11]
      (!db.role_slave && !db.primary_watch && db.secondary_watch) [*2]
      |-> ##[1:2] periph_port_pri_tx_o == '0)
      else $error("peripherals not moved to secondary");
   a_led_pri_label: assert property ( // [R8]
      led_primary_label_o != led_secondary_label_o)
      else $error("indicators lit together or both dark");
   a_chain_forward: assert property ( // [R3]
      (!db.role_slave && !db.primary_watch && db.secondary_watch)
      |=> ##1 active_state_chain_out_o)
      else $error("master decision not forwarded on chain");
   a_slave_ignore: assert property ( // [R4]
      (db.role_slave && $past(db.role_slave) && $stable(db.secondary_watch))
      |=> ##1 $stable(primary_active_contact_o))
      else $error("slave moved on primary watch");
   a_slave_sec_pick: assert property ( // [R17]
      (db.role_slave && db.secondary_watch)
      |=> ##1 secondary_active_contact_o)
      else $error("slave did not pick secondary");
   a_slave_pri_pick: assert property ( // [R4]
      (db.role_slave && !db.secondary_watch)
      |=> ##1 primary_active_contact_o)
      else $error("slave did not pick primary");
   a_slave_fault: assert property ( // [R5]
      (db.role_slave && !db.line_short && !db.line_open)
      |=> ##1 fault_contact_closed_o)
      else $error("fault contact opened on a healthy line");
   a_fault_led_off: assert property ( // [R6]
      !next_fault |=> ##1 !fault_led_o)
      else $error("fault indicator lit without fault");
   a_fault_led_master: assert property ( // [R6]
      !db.role_slave |=> ##1 !fault_led_o)
      else $error("fault indicator lit in master role");

   // channel buses lag their inputs by one cycle
   a_periph_tx_route: assert property ( // [R14]
      !$past(rst_i) |-> periph_port_tx_o == (secondary_active_contact_o ?
      $past(periph_port_sec_rx_i) : $past(periph_port_pri_rx_i)))
      else $error("peripheral receive from wrong side");
   a_periph_pri_route: assert property ( // [R10]
      (!$past(rst_i) && primary_active_contact_o)
      |-> periph_port_pri_tx_o == $past(periph_port_rx_i))
      else $error("peripheral not routed to primary");
   a_periph_sec_route: assert property ( // [R11]
      (!$past(rst_i) && secondary_active_contact_o)
      |-> periph_port_sec_tx_o == $past(periph_port_rx_i) && periph_port_pri_tx_o == '0)
      else $error("peripheral not routed to secondary");
   a_periph_idle: assert property ( // [R14]
      primary_active_contact_o |-> periph_port_sec_tx_o == '0)
      else $error("peripheral sent to inactive side");
   a_evac_pri_route: assert property ( // [R10]
      (!$past(rst_i) && primary_active_contact_o)
      |-> evac_to_pri_o == $past(evac_common_i))
      else $error("evacuation input not routed to primary");
   a_evac_sec_route: assert property ( // [R13]
      (!$past(rst_i) && secondary_active_contact_o)
      |-> evac_to_sec_o == $past(evac_common_i) && evac_to_pri_o == '0)
      else $error("evacuation input not routed to secondary");

   // sticky status, set beats clear
   a_ev_sec_sticky: assert property (
      ev.to_secondary |=> status[`RSC_ST_TO_SEC])
      else $error("switch to secondary not recorded");
   a_ev_pri_sticky: assert property (
      ev.to_primary |=> status[`RSC_ST_TO_PRI])
      else $error("switch to primary not recorded");
   a_ev_fault_sticky: assert property (
      ev.fault |=> status[`RSC_ST_FAULT])
      else $error("fault event not recorded");
   a_clear_drops: assert property (
      (clr[`RSC_ST_TO_SEC] && !ev.to_secondary) |=> !status[`RSC_ST_TO_SEC])
      else $error("cleared status bit still set");
   a_irq_level: assert property (
      !$past(rst_i) |-> irq_o == |(status & $past(enable)))
      else $error("interrupt level disagrees with status");
   a_rdata_idle: assert property (
      !$past(reg_rd_i) |-> reg_rdata_o == `RSC_RD_ZERO)
      else $error("read data outside the read cycle");
   a_rdata_status: assert property (
      (!$past(rst_i) && $past(reg_rd_i) && $past(reg_addr_i) == `RSC_REG_STATUS)
      |-> reg_rdata_o == {{(`RSC_DW-`RSC_EV_W){1'b0}}, $past(status)})
      else $error("status read data wrong");
   a_enable_write: assert property (
      (!$past(rst_i) && $past(reg_wr_i) && $past(reg_addr_i) == `RSC_REG_ENABLE)
      |-> enable == $past(reg_wdata_i[`RSC_EV_W-1:0]))
      else $error("enable write lost");
endmodule : rsc_switchover

// ---- bench/rsc_proc_pair.sv ----
// model of the primary and secondary processors beside the switchover block
`timescale 1ns/1ps
module rsc_proc_pair #(
   parameter logic [7:0] PRI_CONTACT = 8'h00,
   parameter logic [7:0] SEC_CONTACT = 8'h00,
   parameter logic [1:0] PRI_RX = 2'h0,
   parameter logic [1:0] SEC_RX = 2'h0
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic pri_bypass_i,
   input wire logic sec_bypass_i,
   output logic pri_watch_o,
   output logic sec_watch_o,
   output logic [7:0] pri_contact_o,
   output logic [7:0] sec_contact_o,
   output logic [1:0] pri_rx_o,
   output logic [1:0] sec_rx_o
);
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         pri_watch_o <= 1'b1;
         sec_watch_o <= 1'b1;
      end else begin
         pri_watch_o <= ~pri_bypass_i;
         sec_watch_o <= ~sec_bypass_i;
      end
   end
   // fixed patterns so a wrong side shows
   assign pri_contact_o = PRI_CONTACT;
   assign sec_contact_o = SEC_CONTACT;
   assign pri_rx_o = PRI_RX;
   assign sec_rx_o = SEC_RX;
endmodule : rsc_proc_pair

// ---- bench/rsc_switchover_tb.sv ----
// self-checking bench of the switchover block
`timescale 1ns/1ps
`include "rsc_defines.svh"
module rsc_switchover_tb;
   localparam logic [7:0] PC = 8'ha5;
   localparam logic [7:0] SC = 8'h3c;
   localparam logic [1:0] PRX = 2'h1;
   localparam logic [1:0] SRX = 2'h2;
   localparam logic [8:0] EV = 9'h15a;
   localparam logic [1:0] PER = 2'h3;
   logic clk_i = 1'b0;
   logic rst_i, pri_byp, sec_byp, pw, sw, role_slave_i;
   logic secondary_line_short_i, secondary_line_open_i;
   logic reg_wr_i, reg_rd_i, irq_o, pa, sa, chain, fclosed, fled, led_s, led_p, tel;
   logic [7:0] pcon, scon, out_contact_o, reg_wdata_i, reg_rdata_o;
   logic [8:0] evac_common_i, evac_to_pri_o, evac_to_sec_o;
   logic [1:0] periph_port_rx_i, prx_w, srx_w, ptx, pptx, pstx;
   logic [`RSC_AW-1:0] reg_addr_i;
   int errors = 0;
   int compares = 0;

   always #4 clk_i = ~clk_i;

   rsc_proc_pair #(.PRI_CONTACT(PC), .SEC_CONTACT(SC), .PRI_RX(PRX), .SEC_RX(SRX)) proc (
      .clk_i, .rst_i, .pri_bypass_i(pri_byp), .sec_bypass_i(sec_byp),
      .pri_watch_o(pw), .sec_watch_o(sw), .pri_contact_o(pcon), .sec_contact_o(scon),
      .pri_rx_o(prx_w), .sec_rx_o(srx_w));

   // short debounce keeps the run brief
   rsc_switchover #(.STABLE_CYC(4)) dut (
      .clk_i, .rst_i, .primary_watch_input_i(pw), .secondary_watch_input_i(sw),
      .role_slave_i, .secondary_line_short_i, .secondary_line_open_i,
      .out_contact_pri_i(pcon), .out_contact_sec_i(scon), .evac_common_i,
      .periph_port_rx_i, .periph_port_pri_rx_i(prx_w), .periph_port_sec_rx_i(srx_w),
      .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i, .reg_rdata_o, .irq_o,
      .primary_active_contact_o(pa), .secondary_active_contact_o(sa),
      .active_state_chain_out_o(chain), .fault_contact_closed_o(fclosed),
      .fault_led_o(fled), .led_secondary_label_o(led_s), .led_primary_label_o(led_p),
      .out_contact_o, .evac_to_pri_o, .evac_to_sec_o, .periph_port_tx_o(ptx),
      .periph_port_pri_tx_o(pptx), .periph_port_sec_tx_o(pstx),
      .tel_route_secondary_o(tel));

   task automatic end_sim;
      $display("errors %0d compares %0d", errors, compares);
      if (errors == 0 && compares > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask : end_sim

   task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
      compares++;
      if (g !== e) begin
         errors++;
         $display("MISMATCH %s exp %h got %h", nm, e, g);
      end
   endtask : chk

   task automatic wr(input logic [`RSC_AW-1:0] a, input logic [7:0] d);
      @(posedge clk_i);
      reg_addr_i <= a;
      reg_wdata_i <= d;
      reg_wr_i <= 1'b1;
      @(posedge clk_i);
      reg_wr_i <= 1'b0;
   endtask : wr

   task automatic rd(input logic [`RSC_AW-1:0] a, input logic [7:0] e, input string nm);
      @(posedge clk_i);
      reg_addr_i <= a;
      reg_rd_i <= 1'b1;
      @(posedge clk_i);
      reg_rd_i <= 1'b0;
      #1;
      chk(nm, e, reg_rdata_o);
   endtask : rd

   // longer than sync, debounce, decision and output stages together
   task automatic settle;
      repeat (14) @(posedge clk_i);
      #1;
   endtask : settle

   task automatic setw(input logic p, input logic s);
      @(posedge clk_i);
      pri_byp <= ~p;
      sec_byp <= ~s;
      settle();
   endtask : setw

   task automatic check_sel(input logic s);
      chk("pri_act", !s, pa);
      chk("sec_act", s, sa);
      chk("chain", s, chain);
      chk("led_sec_label", !s, led_s);
      chk("led_pri_label", s, led_p);
      chk("out_contact", s ? SC : PC, out_contact_o);
      chk("evac_pri", s ? 9'h0 : EV, evac_to_pri_o);
      chk("evac_sec", s ? EV : 9'h0, evac_to_sec_o);
      chk("periph_tx", s ? SRX : PRX, ptx);
      chk("periph_pri", s ? 2'h0 : PER, pptx);
      chk("periph_sec", s ? PER : 2'h0, pstx);
      chk("tel", s, tel);
   endtask : check_sel

   task automatic check_fault(input logic f);
      chk("fault_contact", !f, fclosed);
      chk("fault_led", f, fled);
   endtask : check_fault

   initial begin
      repeat (5000) @(posedge clk_i);
      errors++;
      end_sim();
   end

   initial begin
      rst_i = 1'b1;
      {pri_byp, sec_byp, role_slave_i, reg_wr_i, reg_rd_i} = '0;
      {secondary_line_short_i, secondary_line_open_i} = '0;
      {reg_addr_i, reg_wdata_i} = '0;
      evac_common_i = EV;
      periph_port_rx_i = PER;
      repeat (4) @(posedge clk_i);
      rst_i <= 1'b0;
      #1;
      chk("pri_act_rst", 1'b1, pa);
      chk("sec_act_rst", 1'b0, sa);
      chk("chain_rst", 1'b0, chain);
      chk("leds_rst", 2'h2, {led_s, led_p});
      chk("routes_rst", 16'h0000, {out_contact_o, ptx, pptx, pstx, tel});
      chk("evac_pri_rst", 9'h000, evac_to_pri_o);
      chk("evac_sec_rst", 9'h000, evac_to_sec_o);
      check_fault(1'b0);
      // routed buses pick up their inputs one cycle after release
      @(posedge clk_i);
      #1;
      check_sel(1'b0);
      chk("irq_reset", 1'b0, irq_o);
      rd(`RSC_REG_ENABLE, 8'h00, "enable_reset");
      rd(`RSC_REG_STATUS, 8'h00, "status_reset");
      wr(`RSC_REG_ENABLE, 8'h01);
      // master truth table, all four combinations
      setw(1'b1, 1'b1);
      check_sel(1'b0);
      setw(1'b1, 1'b0);
      check_sel(1'b0);
      setw(1'b0, 1'b1);
      check_sel(1'b1);
      chk("irq_set", 1'b1, irq_o);
      rd(`RSC_REG_STATE, 8'h21, "state_sec");
      setw(1'b0, 1'b0);
      check_sel(1'b0);
      rd(`RSC_REG_STATUS, 8'h03, "status_both");
      wr(`RSC_REG_CLEAR, 8'h01);
      repeat (2) @(posedge clk_i);
      #1;
      chk("irq_clear", 1'b0, irq_o);
      rd(`RSC_REG_STATUS, 8'h02, "status_left");
      rd(`RSC_REG_ENABLE, 8'h01, "enable_rw");
      wr(`RSC_REG_STATE, 8'hff);
      rd(`RSC_REG_STATE, 8'h00, "state_ro");
      rd(`RSC_REG_CLEAR, 8'h00, "clear_wo");
      rd(4'h2, 8'h00, "unmapped");
      // a short open on the primary watch must not switch
      setw(1'b1, 1'b1);
      @(posedge clk_i);
      pri_byp <= 1'b1;
      repeat (2) @(posedge clk_i);
      pri_byp <= 1'b0;
      settle();
      check_sel(1'b0);
      // slave follows the secondary watch only
      @(posedge clk_i);
      role_slave_i <= 1'b1;
      settle();
      check_sel(1'b1);
      setw(1'b1, 1'b0);
      check_sel(1'b0);
      for (int i = 0; i < 2; i++) begin
         @(posedge clk_i);
         secondary_line_short_i <= (i == 0);
         secondary_line_open_i <= (i == 1);
         settle();
         check_fault(1'b1);
      end
      @(posedge clk_i);
      secondary_line_open_i <= 1'b0;
      settle();
      check_fault(1'b0);
      @(posedge clk_i);
      role_slave_i <= 1'b0;
      secondary_line_short_i <= 1'b1;
      settle();
      check_fault(1'b0);
      rd(`RSC_REG_STATUS, 8'h07, "status_all");
      end_sim();
   end
endmodule : rsc_switchover_tb
